// File: logic/ecc_pkg.sv
// package for the read-merge-write error-correcting memory path:
// widths, check-bit layout, state encoding and the carrier structs.
// assumes one memory controller clock domain and a 64-bit memory word.
package ecc_pkg;

   // -----------------------------------------------------------------
   // widths
   // -----------------------------------------------------------------
   localparam int DATA_W  = 64;
   localparam int CHECK_W = 8;
   localparam int BE_W    = DATA_W / 8;
   localparam int ADDR_W  = 32;
   localparam int SYND_W  = CHECK_W - 1;

   localparam logic [BE_W-1:0]    BE_FULL     = 8'hff;
   localparam logic [DATA_W-1:0]  DATA_RESET  = 64'h0;
   localparam logic [CHECK_W-1:0] CHECK_RESET = 8'h0;
   localparam logic [ADDR_W-1:0]  ADDR_RESET  = 32'h0;
   localparam logic [BE_W-1:0]    BE_RESET    = 8'h0;

   // -----------------------------------------------------------------
   // check-bit layout
   // -----------------------------------------------------------------
   // hamming position of data bit j: the j-th index from 3 upward that is
   // not a power of two; check bits sit at 1,2,4..64, overall parity last
   function automatic int dataPos(input int j);
      int p;
      int n;
      p = 2;
      n = -1;
      while (n < j) begin
         p = p + 1;
         if ((p & (p - 1)) != 0) begin
            n = n + 1;
         end
      end
      return p;
   endfunction

   function automatic logic [DATA_W-1:0] checkMask(input int k);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int j = 0; j < DATA_W; j++) begin
         m[j] = ((dataPos(j) >> k) & 1) == 1;
      end
      return m;
   endfunction

   // -----------------------------------------------------------------
   // state and carriers
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RD_CMD,
      ST_RD_WAIT,
      ST_WR_CMD
   } state_e;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [BE_W-1:0]   byteEn;
   } req_s;

   typedef struct packed {
      logic               write;
      logic [ADDR_W-1:0]  addr;
      logic [DATA_W-1:0]  data;
      logic [CHECK_W-1:0] check;
      logic [BE_W-1:0]    byteEn;
   } memCmd_s;

   typedef struct packed {
      logic [DATA_W-1:0]  data;
      logic [CHECK_W-1:0] check;
   } memRd_s;

   typedef struct packed {
      logic              write;
      logic [DATA_W-1:0] data;
      logic              corrected;
      logic              uncorrectable;
   } rsp_s;

endpackage

// File: logic/secded_codec.sv
// single-error-correct, double-error-detect codec over one 64-bit word.
// purely combinational; the caller registers whatever it needs.
`timescale 1ns/100ps

module secded_codec (
   // encoder
   input  wire logic [ecc_pkg::DATA_W-1:0]  encData,
   output logic      [ecc_pkg::CHECK_W-1:0] encCheck,
   // decoder
   input  wire logic [ecc_pkg::DATA_W-1:0]  decData,
   input  wire logic [ecc_pkg::CHECK_W-1:0] decCheck,
   output logic      [ecc_pkg::DATA_W-1:0]  decFixed,
   output logic                             decSingle,
   output logic                             decDouble
);

   // -----------------------------------------------------------------
   // check bits: hamming bits per mask, top bit is overall parity
   // -----------------------------------------------------------------
   logic [ecc_pkg::SYND_W-1:0] encHam;
   logic [ecc_pkg::SYND_W-1:0] decHam;
   logic [ecc_pkg::SYND_W-1:0] syndrome;
   logic                       parityBad;

   genvar k;
   generate
      for (k = 0; k < ecc_pkg::SYND_W; k++) begin : g_check
         localparam logic [ecc_pkg::DATA_W-1:0] MASK = ecc_pkg::checkMask(k);
         assign encHam[k] = ^(encData & MASK);                          // [R2]
         assign decHam[k] = ^(decData & MASK);
      end
   endgenerate

   assign encCheck  = {^{encData, encHam}, encHam};                     // [R2]
   assign syndrome  = decHam ^ decCheck[ecc_pkg::SYND_W-1:0];
   assign parityBad = ^{decData, decCheck};

   // odd parity flags a single flip (a zero syndrome means the parity bit
   // itself); a nonzero syndrome with even parity is two flips
   assign decSingle = parityBad;                                        // [R7]
   assign decDouble = !parityBad && (syndrome != '0);                   // [R7]

   genvar j;
   generate
      for (j = 0; j < ecc_pkg::DATA_W; j++) begin : g_fix
         localparam logic [ecc_pkg::SYND_W-1:0] POS =
            ecc_pkg::SYND_W'(ecc_pkg::dataPos(j));
         assign decFixed[j] = decData[j] ^ (parityBad && (syndrome == POS)); // [R6] [R7]
      end
   endgenerate

endmodule // secded_codec

// File: logic/ecc_read_merge_write.sv
// memory-path engine between the system request side and the sdram word port.
// assumes one clock domain, one outstanding memory command, and read data
// returned by the memory some cycles after its read command is taken.
//
// Contract
// [R1] A configuration input turns the error-correcting integrity mode on or off.
// [R2] With the mode on, an 8-bit check code is computed over every 64-bit word written.
// [R3] With the mode on, every memory write stores a whole 64-bit word plus its code at once.
// [R4] A write narrower than a full word is done as read-merge-write, never as a partial write; the code does so only with the mode on.
// [R5] The merge reads the word, inserts new bytes, recodes the result and writes word and code.
// [R6] A single-bit error in the word read for a merge is corrected before the new bytes go in.
// [R7] With the mode on, reads correct single-bit errors and flag multi-bit errors uncorrectable; the code detects only double-bit errors.
// [R8] With the mode off, no code is made or checked and partial writes use byte enables directly.
`timescale 1ns/100ps

module ecc_read_merge_write (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // configuration
   input  wire logic             eccEnable,
   // system request side
   input  wire logic             reqValid,
   output logic                  reqReady,
   input  wire ecc_pkg::req_s    req,
   // system response side
   output logic                  rspValid,
   output ecc_pkg::rsp_s         rsp,
   // memory command port
   output logic                  memCmdValid,
   input  wire logic             memCmdReady,
   output ecc_pkg::memCmd_s      memCmd,
   // memory read return
   input  wire logic             memRdValid,
   input  wire ecc_pkg::memRd_s  memRd
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   ecc_pkg::state_e  state_r,   state_nxt;
   ecc_pkg::memCmd_s cmd_r,     cmd_nxt;
   ecc_pkg::rsp_s    rsp_r,     rsp_nxt;
   logic             rspVld_r,  rspVld_nxt;
   logic             eccOn_r,   eccOn_nxt;
   logic             isRead_r,  isRead_nxt;
   logic [ecc_pkg::DATA_W-1:0] newData_r, newData_nxt;
   logic [ecc_pkg::BE_W-1:0]   newBe_r,   newBe_nxt;
   logic                       fixOld_r,  fixOld_nxt;

   // -----------------------------------------------------------------
   // codec
   // -----------------------------------------------------------------
   logic [ecc_pkg::DATA_W-1:0]  encIn;
   logic [ecc_pkg::CHECK_W-1:0] encOut;
   logic [ecc_pkg::DATA_W-1:0]  fixedData;
   logic                        single;
   logic                        double;
   logic [ecc_pkg::DATA_W-1:0]  merged;

   secded_codec u_codec (
      .encData   (encIn),
      .encCheck  (encOut),
      .decData   (memRd.data),
      .decCheck  (memRd.check),
      .decFixed  (fixedData),
      .decSingle (single),
      .decDouble (double)
   );

   // new bytes go over the corrected old word, byte by byte
   genvar b;
   generate
      for (b = 0; b < ecc_pkg::BE_W; b++) begin : g_merge
         assign merged[8*b +: 8] = newBe_r[b] ? newData_r[8*b +: 8]
                                              : fixedData[8*b +: 8];   // [R5] [R6]
      end
   endgenerate

   // the encoder sees the incoming word in idle and the merged word otherwise
   assign encIn = (state_r == ecc_pkg::ST_IDLE) ? req.data : merged;

   // -----------------------------------------------------------------
   // handshakes and outputs
   // -----------------------------------------------------------------
   assign reqReady    = (state_r == ecc_pkg::ST_IDLE);
   assign memCmdValid = (state_r == ecc_pkg::ST_RD_CMD) || (state_r == ecc_pkg::ST_WR_CMD);
   assign memCmd      = cmd_r;
   assign rspValid    = rspVld_r;
   assign rsp         = rsp_r;

   // -----------------------------------------------------------------
   // next-state logic
   // -----------------------------------------------------------------
   always_comb begin
      state_nxt   = state_r;
      cmd_nxt     = cmd_r;
      rsp_nxt     = rsp_r;
      rspVld_nxt  = 1'b0;
      eccOn_nxt   = eccOn_r;
      isRead_nxt  = isRead_r;
      newData_nxt = newData_r;
      newBe_nxt   = newBe_r;
      fixOld_nxt  = fixOld_r;

      case (state_r)
         ecc_pkg::ST_IDLE: begin
            if (reqValid) begin
               // mode is caught per request so a change never splits a merge
               eccOn_nxt    = eccEnable;                                 // [R1]
               isRead_nxt   = !req.write;
               newData_nxt  = req.data;
               newBe_nxt    = req.byteEn;
               fixOld_nxt   = 1'b0;
               cmd_nxt.addr = req.addr;
               if (!req.write) begin
                  // a plain read fetches the whole word so its code can be checked
                  cmd_nxt.write  = 1'b0;
                  cmd_nxt.byteEn = ecc_pkg::BE_FULL;
                  cmd_nxt.data   = ecc_pkg::DATA_RESET;
                  cmd_nxt.check  = ecc_pkg::CHECK_RESET;
                  state_nxt      = ecc_pkg::ST_RD_CMD;
               end else if (eccEnable && (req.byteEn != ecc_pkg::BE_FULL)) begin
                  // partial write under the code: fetch the old word first
                  cmd_nxt.write  = 1'b0;                                  // [R4]
                  cmd_nxt.byteEn = ecc_pkg::BE_FULL;
                  cmd_nxt.data   = ecc_pkg::DATA_RESET;
                  cmd_nxt.check  = ecc_pkg::CHECK_RESET;
                  state_nxt      = ecc_pkg::ST_RD_CMD;                    // [R5]
               end else begin
                  cmd_nxt.write  = 1'b1;
                  cmd_nxt.data   = req.data;
                  cmd_nxt.byteEn = eccEnable ? ecc_pkg::BE_FULL : req.byteEn; // [R3] [R8]
                  cmd_nxt.check  = eccEnable ? encOut : ecc_pkg::CHECK_RESET; // [R2] [R8]
                  state_nxt      = ecc_pkg::ST_WR_CMD;
               end
            end
         end

         ecc_pkg::ST_RD_CMD: begin
            // return data is ignored until the read command has been taken
            if (memCmdReady) begin
               state_nxt = ecc_pkg::ST_RD_WAIT;
            end
         end

         ecc_pkg::ST_RD_WAIT: begin
            if (memRdValid) begin
               if (isRead_r) begin
                  rspVld_nxt            = 1'b1;
                  rsp_nxt.write         = 1'b0;
                  rsp_nxt.data          = eccOn_r ? fixedData : memRd.data; // [R7] [R8]
                  rsp_nxt.corrected     = eccOn_r && single;              // [R7]
                  rsp_nxt.uncorrectable = eccOn_r && double;              // [R7]
                  state_nxt             = ecc_pkg::ST_IDLE;
               end else if (double) begin
                  // never recode a word known to be bad: that would hide it
                  rspVld_nxt            = 1'b1;
                  rsp_nxt.write         = 1'b1;
                  rsp_nxt.data          = ecc_pkg::DATA_RESET;
                  rsp_nxt.corrected     = 1'b0;
                  rsp_nxt.uncorrectable = 1'b1;
                  state_nxt             = ecc_pkg::ST_IDLE;
               end else begin
                  cmd_nxt.write         = 1'b1;
                  cmd_nxt.data          = merged;                         // [R5] [R6]
                  cmd_nxt.check         = encOut;                         // [R5]
                  cmd_nxt.byteEn        = ecc_pkg::BE_FULL;               // [R3]
                  // held aside so rsp never moves before its own rspValid
                  fixOld_nxt            = single;                         // [R6]
                  state_nxt             = ecc_pkg::ST_WR_CMD;
               end
            end
         end

         ecc_pkg::ST_WR_CMD: begin
            if (memCmdReady) begin
               rspVld_nxt            = 1'b1;
               rsp_nxt.write         = 1'b1;
               rsp_nxt.data          = ecc_pkg::DATA_RESET;
               rsp_nxt.uncorrectable = 1'b0;
               // only a merge can have fixed an old bit; plain writes report 0
               rsp_nxt.corrected     = fixOld_r;                         // [R6]
               state_nxt             = ecc_pkg::ST_IDLE;
            end
         end

         default: begin
            state_nxt = ecc_pkg::ST_IDLE;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r   <= ecc_pkg::ST_IDLE;
         cmd_r     <= '{write: 1'b0, addr: ecc_pkg::ADDR_RESET, data: ecc_pkg::DATA_RESET,
                        check: ecc_pkg::CHECK_RESET, byteEn: ecc_pkg::BE_RESET};
         rsp_r     <= '{write: 1'b0, data: ecc_pkg::DATA_RESET,
                        corrected: 1'b0, uncorrectable: 1'b0};
         rspVld_r  <= 1'b0;
         eccOn_r   <= 1'b0;
         isRead_r  <= 1'b0;
         newData_r <= ecc_pkg::DATA_RESET;
         newBe_r   <= ecc_pkg::BE_RESET;
         fixOld_r  <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         cmd_r     <= cmd_nxt;
         rsp_r     <= rsp_nxt;
         rspVld_r  <= rspVld_nxt;
         eccOn_r   <= eccOn_nxt;
         isRead_r  <= isRead_nxt;
         newData_r <= newData_nxt;
         newBe_r   <= newBe_nxt;
         fixOld_r  <= fixOld_nxt;
      end
   end

endmodule // ecc_read_merge_write

// File: sim/ecc_rmw_chk.sv
// ---------------------------------------------
// checker for the read-merge-write engine ports
// ---------------------------------------------
// assumes the memory answers each command within about 60 cycles
`timescale 1ns/100ps
module ecc_rmw_chk (
   // clock and reset
   input wire logic             clk,
   input wire logic             reset_n,
   // request side
   input wire logic             eccEnable,
   input wire logic             reqValid,
   input wire logic             reqReady,
   input wire ecc_pkg::req_s    req,
   input wire logic             rspValid,
   input wire ecc_pkg::rsp_s    rsp,
   // memory side
   input wire logic             memCmdValid,
   input wire logic             memCmdReady,
   input wire ecc_pkg::memCmd_s memCmd,
   input wire logic             memRdValid,
   input wire ecc_pkg::memRd_s  memRd
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic take;
   logic mode_r;
   logic mode_nxt;
   logic wr_r;
   logic wr_nxt;
   assign take = reqValid && reqReady;
   // mode is caught at acceptance, so track it the same way
   always_comb begin
      mode_nxt = take ? eccEnable : mode_r;
      wr_nxt   = take ? req.write : wr_r;
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_r <= 1'b0;
         wr_r   <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         wr_r   <= wr_nxt;
      end
   end
   property p_off;
      take && !eccEnable && req.write |=> memCmdValid && memCmd.write
         && memCmd.check == 8'h00 && memCmd.byteEn == $past(req.byteEn);
   endproperty
   a_off: assert property (p_off) else $error("mode off write not direct");
   property p_parity;
      memCmdValid && memCmd.write && mode_r |-> ^{memCmd.data, memCmd.check} == 1'b0;
   endproperty
   a_parity: assert property (p_parity) else $error("code parity wrong");
   property p_full;
      take && eccEnable && req.write && req.byteEn == 8'hff |=> memCmd.write
         && memCmd.data == $past(req.data) && memCmd.byteEn == 8'hff;
   endproperty
   a_full: assert property (p_full) else $error("full write not whole");
   property p_hold;
      memCmdValid && !memCmdReady |=> memCmdValid && $stable(memCmd);
   endproperty
   a_hold: assert property (p_hold) else $error("command moved while waiting");
   property p_part;
      take && eccEnable && req.write && req.byteEn != 8'hff |=> memCmdValid
         && !memCmd.write && memCmd.addr == $past(req.addr);
   endproperty
   a_part: assert property (p_part) else $error("partial write not read first");
   property p_merge;
      take && eccEnable && req.write && req.byteEn != 8'hff |-> ##[2:60]
         ((memCmdValid && memCmd.write && memCmd.byteEn == 8'hff) || rspValid);
   endproperty
   a_merge: assert property (p_merge) else $error("merge write missing");
   property p_done;
      memCmdValid && memCmdReady && memCmd.write |=> rspValid && rsp.write;
   endproperty
   a_done: assert property (p_done) else $error("write not answered");
   property p_read;
      memRdValid && !reqReady && !memCmdValid && !wr_r |=> rspValid && !rsp.write;
   endproperty
   a_read: assert property (p_read) else $error("read not answered");
endmodule // ecc_rmw_chk

bind ecc_read_merge_write ecc_rmw_chk u_ecc_rmw_chk (.clk, .reset_n, .eccEnable,
   .reqValid, .reqReady, .req, .rspValid, .rsp, .memCmdValid, .memCmdReady, .memCmd,
   .memRdValid, .memRd);

// File: sim/mem_model.sv
// ---------------------------------
// word memory with data and code
// ---------------------------------
// flip corrupts returned data only; stall slows acceptance and return
`timescale 1ns/100ps
module mem_model (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // command port
   input  wire logic             memCmdValid,
   output logic                  memCmdReady,
   input  wire ecc_pkg::memCmd_s memCmd,
   // read return
   output logic                  memRdValid,
   output ecc_pkg::memRd_s       memRd,
   // fault and pace control
   input  wire logic             stall,
   input  wire logic [63:0]      flip
);
   // four words are enough: the bench only ever addresses 0 to 3
   ecc_pkg::memRd_s store [4];
   logic [1:0]      rdAddr;
   logic [1:0]      pace;
   int              waitCnt;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         memCmdReady <= 1'b0;
         memRdValid  <= 1'b0;
         memRd       <= '0;
         pace        <= 2'h0;
         waitCnt     <= 0;
      end else begin
         pace        <= pace + 2'h1;
         memCmdReady <= !stall || pace == 2'h3;
         memRdValid  <= waitCnt == 1;
         // idle return lines keep toggling so stale data is never seen
         memRd <= (waitCnt == 1) ? {store[rdAddr].data ^ flip, store[rdAddr].check} : ~memRd;
         if (waitCnt > 0)
            waitCnt <= waitCnt - 1;
         if (memCmdValid && memCmdReady) begin
            if (memCmd.write) begin
               for (int b = 0; b < 8; b++)
                  if (memCmd.byteEn[b])
                     store[memCmd.addr[1:0]].data[8*b+:8] <= memCmd.data[8*b+:8];
               if (memCmd.byteEn == 8'hff)
                  store[memCmd.addr[1:0]].check <= memCmd.check;
            end else begin
               rdAddr  <= memCmd.addr[1:0];
               waitCnt <= stall ? 4 : 2;
            end
         end
      end
   end
endmodule // mem_model

// File: sim/ecc_read_merge_write_tb.sv
// ----------------------------------
// self-checking bench for the engine
// ----------------------------------
// drives requests at the falling edge; mem_model stands at the far side
`timescale 1ns/100ps
module ecc_read_merge_write_tb;
   logic              clk = 1'b0;
   logic              reset_n;
   logic              eccEnable;
   logic              reqValid;
   logic              reqReady;
   logic              rspValid;
   logic              memCmdValid;
   logic              memCmdReady;
   logic              memRdValid;
   logic              stall;
   logic [63:0]       flip;
   logic [63:0]       shadow [4];
   ecc_pkg::req_s     req;
   ecc_pkg::rsp_s     rsp;
   ecc_pkg::memCmd_s  memCmd;
   ecc_pkg::memRd_s   memRd;
   ecc_pkg::rsp_s     expQ [$];
   int                error_cnt = 0;
   int                total_checks = 0;
   always #50 clk = ~clk;
   ecc_read_merge_write u_ecc_read_merge_write (.clk, .reset_n, .eccEnable, .reqValid,
      .reqReady, .req, .rspValid, .rsp, .memCmdValid, .memCmdReady, .memCmd, .memRdValid,
      .memRd);
   mem_model u_mem_model (.clk, .reset_n, .memCmdValid, .memCmdReady, .memCmd,
      .memRdValid, .memRd, .stall, .flip);
   function automatic logic [7:0] tbEnc(input logic [63:0] d);
      logic [7:0] c;
      int         p;
      c = '0;
      p = 3;
      for (int j = 0; j < 64; j++) begin
         while ((p & (p - 1)) == 0)
            p++;
         for (int k = 0; k < 7; k++)
            if (p[k])
               c[k] ^= d[j];
         p++;
      end
      c[7] = ^d ^ ^c[6:0];
      return c;
   endfunction
   task automatic note(input logic ok, input string what);
      total_checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask
   task automatic cmpRsp(input ecc_pkg::rsp_s g, input ecc_pkg::rsp_s e);
      note(g.write === e.write && g.corrected === e.corrected
         && g.uncorrectable === e.uncorrectable, "response flags");
      if (!e.write && !e.uncorrectable)
         note(g.data === e.data, "read data");
   endtask
   task automatic cmpCode(input ecc_pkg::memCmd_s c, input logic on);
      note(c.check === (on ? tbEnc(c.data) : 8'h00), "check code");
      if (on)
         note(c.byteEn === 8'hff, "whole word write");
   endtask
   always @(posedge clk) begin
      if (reset_n && rspValid === 1'b1) begin
         if (expQ.size() == 0)
            note(1'b0, "stray response");
         else
            cmpRsp(rsp, expQ.pop_front());
      end
      if (reset_n && memCmdValid && memCmdReady && memCmd.write)
         cmpCode(memCmd, eccEnable);
   end
   task automatic doReq(input logic wr, input logic [1:0] a, input logic [63:0] d,
                        input logic [7:0] be, input logic [63:0] fl);
      ecc_pkg::rsp_s e;
      logic [63:0]   m;
      int            n;
      for (int b = 0; b < 8; b++)
         m[8*b+:8] = {8{be[b]}};
      e.write         = wr;
      e.corrected     = eccEnable && $countones(fl) == 1 && (!wr || be != 8'hff);
      e.uncorrectable = eccEnable && $countones(fl) == 2 && (!wr || be != 8'hff);
      e.data          = eccEnable ? shadow[a] : shadow[a] ^ fl;
      // a merge over a double error must leave the stored word alone
      if (wr && !e.uncorrectable)
         shadow[a] = (shadow[a] & ~m) | (d & m);
      expQ.push_back(e);
      flip = fl;
      n = 0;
      while (reqReady !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (reqReady !== 1'b1)
         note(1'b0, "engine never ready");
      reqValid = 1'b1;
      req = '{wr, {30'h0, a}, d, be};
      @(negedge clk);
      reqValid = 1'b0;
      n = 0;
      while (expQ.size() != 0 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n == 200)
         note(1'b0, "no response");
      flip = '0;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      #2000000;
      error_cnt++;
      end_of_test;
   end
   initial begin
      reset_n   = 1'b0;
      eccEnable = 1'b1;
      reqValid  = 1'b0;
      req       = '0;
      stall     = 1'b0;
      flip      = '0;
      void'($urandom(32'heb346e83));
      repeat (6) @(negedge clk);
      reset_n = 1'b1;
      for (int a = 0; a < 4; a++)
         doReq(1'b1, 2'(a), {$urandom, $urandom}, 8'hff, '0);
      $display("test full writes done");
      for (int i = 0; i < 8; i++) begin
         stall = i[0];
         doReq(1'b1, 2'($urandom_range(0, 3)), {$urandom, $urandom},
               8'($urandom_range(1, 254)), '0);
      end
      stall = 1'b0;
      for (int a = 0; a < 4; a++)
         doReq(1'b0, 2'(a), '0, 8'hff, '0);
      $display("test partial writes done");
      doReq(1'b1, 2'h1, {$urandom, $urandom}, 8'h0f, 64'h1 << $urandom_range(32, 63));
      doReq(1'b0, 2'h1, '0, 8'hff, '0);
      doReq(1'b0, 2'h2, '0, 8'hff, 64'h1 << $urandom_range(0, 63));
      doReq(1'b0, 2'h3, '0, 8'hff, 64'h3);
      doReq(1'b1, 2'h2, {$urandom, $urandom}, 8'hf0, 64'h5);
      doReq(1'b0, 2'h2, '0, 8'hff, '0);
      $display("test error fixing done");
      eccEnable = 1'b0;
      doReq(1'b1, 2'h0, {$urandom, $urandom}, 8'h3c, '0);
      doReq(1'b0, 2'h0, '0, 8'hff, 64'h10);
      $display("test mode off done");
      end_of_test;
   end
endmodule // ecc_read_merge_write_tb
